// ==== logic/ewr_map.svh ====
// register offsets, field positions, reset values and limits of the edge readout block
`ifndef EWR_MAP_SVH
`define EWR_MAP_SVH

// ----------------------------------------------------------------------
// register port geometry
// ----------------------------------------------------------------------
`define EWR_ADDR_W 20
`define EWR_DATA_W 16

// ----------------------------------------------------------------------
// holding register offsets
// ----------------------------------------------------------------------
`define EWR_OFS_WAVE_SET 20'h62549
`define EWR_OFS_WAVE_DATA 20'h6254b
`define EWR_OFS_WAVE_LAST 20'h625ca
`define EWR_OFS_EDGE_RDSET 20'h625e1
`define EWR_OFS_EDGE_INFO 20'h625e3
`define EWR_OFS_MEAS_LO 20'h625e5
`define EWR_OFS_MEAS_HI 20'h625e6
`define EWR_OFS_EDGE_POS 20'h625e7
`define EWR_OFS_REVERSE 20'h62647
`define EWR_OFS_SPAN 20'h62650

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define EWR_BIT_STATUS 9
`define EWR_BIT_EDGE_POL 15
`define EWR_BIT_MODE_HI 14
`define EWR_BIT_MODE_LO 13
`define EWR_BIT_INVERT 0

// ----------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------
`define EWR_RST_WAVE_TYPE 8'h11
`define EWR_RST_INVERT 1'b0
`define EWR_MEAS_MAX 32'sd1999999
`define EWR_MEAS_MIN -32'sd1999999
`define EWR_WAVE_AREAS 256
`define EWR_EDGE_THRESH 8'h80

`endif

// ==== logic/ewr_pkg.sv ====
// types shared by the edge readout block
package ewr_pkg;
  // measurement mode reported by the core
  typedef enum logic [1:0] {EWR_MODE_EDGE, EWR_MODE_CENTER, EWR_MODE_AUTO} ewr_mode_t;
  // effective edge mode field, codes follow declaration order
  typedef enum logic [1:0] {EWR_EDGE_NONE, EWR_EDGE_ONE, EWR_EDGE_BOTH} ewr_edge_mode_t;
endpackage : ewr_pkg

// ==== logic/ewr_wave_if.sv ====
// link between register logic and waveform buffer
`timescale 1ns/1ns
`default_nettype none
interface ewr_wave_if;
  logic snap_req;
  logic [6:0] rd_word;
  logic [15:0] rd_data;
  ewr_pkg::ewr_edge_mode_t edge_mode;
  logic [7:0] edge_pos0;
  logic [7:0] edge_pos1;
  logic edge_pol0;
  modport buf_side (input snap_req, input rd_word, output rd_data, output edge_mode,
                    output edge_pos0, output edge_pos1, output edge_pol0);
  modport ctl_side (output snap_req, output rd_word, input rd_data, input edge_mode,
                    input edge_pos0, input edge_pos1, input edge_pol0);
endinterface : ewr_wave_if
`default_nettype wire

// ==== logic/ewr_wave_buf.sv ====
// live and snapshot waveform store with edge finder
`include "ewr_map.svh"
`timescale 1ns/1ns
`default_nettype none
module ewr_wave_buf #(
  parameter int AREAS = `EWR_WAVE_AREAS,
  parameter logic [7:0] THRESH = `EWR_EDGE_THRESH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // waveform samples from the receiver, index 0 first
  input wire logic samp_valid,
  input wire logic [7:0] samp_idx,
  input wire logic [7:0] samp_level,
  // register side
  ewr_wave_if.buf_side wif
);
  import ewr_pkg::*;

  // ----------------------------------------------------------------------
  // waveform memories
  // ----------------------------------------------------------------------
  logic [7:0] live_mem [AREAS];
  logic [7:0] snap_mem [AREAS];

  // area index 0 is the top of the receiver, 256 areas of 256 levels
  always_ff @(posedge sys_clk) begin
    if (samp_valid) begin
      live_mem[samp_idx] <= samp_level; // RULE5 RULE8
    end
  end

  // whole-store copy in one cycle; a copy taken while a frame is arriving holds parts of two waveforms
  always_ff @(posedge sys_clk) begin
    if (wif.snap_req) begin
      for (int i = 0; i < AREAS; i++) begin
        snap_mem[i] <= live_mem[i]; // RULE11
      end
    end
  end

  // two areas per word, lower index in the high byte
  assign wif.rd_data = {snap_mem[{wif.rd_word, 1'b0}], snap_mem[{wif.rd_word, 1'b1}]};

  // ----------------------------------------------------------------------
  // edge finder
  // ----------------------------------------------------------------------
  logic [1:0] cnt_reg, cnt_next;
  logic [7:0] p0_reg, p0_next, p1_reg, p1_next;
  logic pol_reg, pol_next, hi_reg, hi_next;
  ewr_edge_mode_t pub_mode_reg, pub_mode_next;
  logic [7:0] pub_p0_reg, pub_p0_next, pub_p1_reg, pub_p1_next;
  logic pub_pol_reg, pub_pol_next;

  // a crossing of the threshold marks the border of shade and light
  always_comb begin
    logic hi_now;
    logic [1:0] base;
    hi_now = samp_level >= THRESH;
    base = (samp_idx == 8'h00) ? 2'h0 : cnt_reg;
    cnt_next = cnt_reg;
    p0_next = p0_reg;
    p1_next = p1_reg;
    pol_next = pol_reg;
    hi_next = hi_reg;
    pub_mode_next = pub_mode_reg;
    pub_p0_next = pub_p0_reg;
    pub_p1_next = pub_p1_reg;
    pub_pol_next = pub_pol_reg;
    if (samp_valid) begin
      cnt_next = base;
      hi_next = hi_now;
      if (samp_idx != 8'h00 && hi_now != hi_reg && base != 2'h2) begin
        if (base == 2'h0) begin
          p0_next = samp_idx; // RULE7 RULE8
          pol_next = hi_now; // RULE2
        end else begin
          p1_next = samp_idx; // RULE7
        end
        cnt_next = base + 2'h1;
      end
      // publish only a complete frame
      if (samp_idx == 8'hff) begin
        pub_mode_next = ewr_edge_mode_t'(cnt_next); // RULE1
        pub_p0_next = p0_next;
        pub_p1_next = p1_next;
        pub_pol_next = pol_next;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 2'h0;
      p0_reg <= 8'h00;
      p1_reg <= 8'h00;
      pol_reg <= 1'b0;
      hi_reg <= 1'b0;
      pub_mode_reg <= EWR_EDGE_NONE;
      pub_p0_reg <= 8'h00;
      pub_p1_reg <= 8'h00;
      pub_pol_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      p0_reg <= p0_next;
      p1_reg <= p1_next;
      pol_reg <= pol_next;
      hi_reg <= hi_next;
      pub_mode_reg <= pub_mode_next;
      pub_p0_reg <= pub_p0_next;
      pub_p1_reg <= pub_p1_next;
      pub_pol_reg <= pub_pol_next;
    end
  end

  assign wif.edge_mode = pub_mode_reg;
  assign wif.edge_pos0 = pub_p0_reg;
  assign wif.edge_pos1 = pub_p1_reg;
  assign wif.edge_pol0 = pub_pol_reg;

  a_edge_order: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE7
    (pub_mode_reg == EWR_EDGE_BOTH) |-> (pub_p0_reg < pub_p1_reg))
    else $error("second edge not below first edge");
endmodule : ewr_wave_buf
`default_nettype wire

// ==== logic/ewr_readout.sv ====
// edge data and waveform readout registers of the sensor link
//
// Overview of operation
// [RULE1] edge info bits 14:13 give effective edge mode: none, one, both.
// [RULE2] each edge carries its own rising or falling indication; only edge 0's polarity is kept, in bit 15.
// [RULE3] captured measured value is signed, clamped to -1999999..1999999.
// [RULE4] two edge positions packed one byte each in one 16-bit word.
// [RULE5] waveform is 256 areas, each with an 8-bit intensity.
// [RULE6] start and end points readable only in reference acquisition mode.
// [RULE7] an edge sits where intensity crosses between shade and light.
// [RULE8] edge positions count from zero at the receiver top.
// [RULE9] auto mode shows insertion direction, other modes the direction setting.
// [RULE10] accepted setting changes are pushed to nonvolatile storage; only reverse writes are stored, not the waveform type.
// [RULE11] reading the waveform setting saves a snapshot of the waveform.
// [RULE12] host writes only printable codes, 0x20 for space.
// [RULE13] host spaces commands by 1 ms; waveform refreshes every 64 ms.
// [RULE14] edge info, positions and value are captured in one event.
`include "ewr_map.svh"
`timescale 1ns/1ns
`default_nettype none
module ewr_readout #(
  parameter logic [7:0] THRESH = `EWR_EDGE_THRESH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register port
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [`EWR_ADDR_W-1:0] reg_addr,
  input wire logic [`EWR_DATA_W-1:0] reg_wdata,
  output logic [`EWR_DATA_W-1:0] reg_rdata,
  output logic reg_ack,
  output logic reg_err,
  // measurement core
  input wire logic signed [31:0] meas_value,
  input wire ewr_pkg::ewr_mode_t meas_mode,
  input wire logic insert_dir,
  input wire logic dir_setting,
  input wire logic ref_mode,
  input wire logic [7:0] span_start,
  input wire logic [7:0] span_end,
  // waveform samples
  input wire logic samp_valid,
  input wire logic [7:0] samp_idx,
  input wire logic [7:0] samp_level,
  // direction and nonvolatile store
  output logic dir_status,
  output logic measured_value_invert,
  output logic nv_wr,
  output logic [`EWR_DATA_W-1:0] nv_data
);
  import ewr_pkg::*;

  // ----------------------------------------------------------------------
  // waveform buffer
  // ----------------------------------------------------------------------
  ewr_wave_if wif ();

  ewr_wave_buf #(
    .AREAS(`EWR_WAVE_AREAS),
    .THRESH(THRESH)
  ) u_wave (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .samp_valid(samp_valid),
    .samp_idx(samp_idx),
    .samp_level(samp_level),
    .wif(wif.buf_side)
  );

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [15:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next, err_reg, err_next;
  logic [7:0] wtype_reg, wtype_next;
  logic wsaved_reg, wsaved_next, esaved_reg, esaved_next;
  logic [15:0] einfo_reg, einfo_next, epos_reg, epos_next;
  logic signed [31:0] emeas_reg, emeas_next;
  logic rev_reg, rev_next, dir_reg, dir_next;
  logic nv_wr_reg, nv_wr_next;
  logic [15:0] nv_data_reg, nv_data_next;
  ewr_mode_t mode_prev_reg, mode_prev_next;
  logic snap_reg, snap_next;

  // ----------------------------------------------------------------------
  // decode and value shaping
  // ----------------------------------------------------------------------
  logic acc, in_wave;
  logic [`EWR_ADDR_W-1:0] wave_ofs;
  logic signed [31:0] meas_adj, meas_lim;

  assign acc = reg_rd | reg_wr;
  assign in_wave = (reg_addr >= `EWR_OFS_WAVE_DATA) && (reg_addr <= `EWR_OFS_WAVE_LAST);
  assign wave_ofs = reg_addr - `EWR_OFS_WAVE_DATA;
  assign wif.rd_word = wave_ofs[6:0];
  assign wif.snap_req = snap_reg;

  // reversal is applied before the clamp so both signs stay in range
  assign meas_adj = rev_reg ? -meas_value : meas_value;
  assign meas_lim = (meas_adj > `EWR_MEAS_MAX) ? `EWR_MEAS_MAX :
                    (meas_adj < `EWR_MEAS_MIN) ? `EWR_MEAS_MIN : meas_adj; // RULE3

  // ----------------------------------------------------------------------
  // register access and captures
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_next = 16'h0000;
    ack_next = acc;
    err_next = 1'b0;
    wtype_next = wtype_reg;
    wsaved_next = wsaved_reg;
    esaved_next = esaved_reg;
    einfo_next = einfo_reg;
    epos_next = epos_reg;
    emeas_next = emeas_reg;
    rev_next = rev_reg;
    nv_wr_next = 1'b0;
    nv_data_next = nv_data_reg;
    snap_next = 1'b0;
    mode_prev_next = meas_mode;
    // a mode change invalidates saved data; a save in the same cycle wins
    if (meas_mode != mode_prev_reg) begin
      wsaved_next = 1'b0;
      esaved_next = 1'b0;
    end
    if (reg_rd) begin
      if (in_wave) begin
        // zero until a snapshot is saved; a read in the cycle right after the saving read still returns the store before the copy
        rdata_next = wsaved_reg ? wif.rd_data : 16'h0000; // RULE5
      end else begin
        unique case (reg_addr)
          `EWR_OFS_WAVE_SET: begin
            snap_next = 1'b1; // RULE11
            wsaved_next = 1'b1;
            rdata_next = {6'h00, 1'b1, 1'b0, wtype_reg};
          end
          `EWR_OFS_EDGE_RDSET: rdata_next = {6'h00, esaved_reg, 9'h000};
          `EWR_OFS_EDGE_INFO: rdata_next = einfo_reg;
          `EWR_OFS_MEAS_LO: rdata_next = emeas_reg[15:0];
          `EWR_OFS_MEAS_HI: rdata_next = emeas_reg[31:16];
          `EWR_OFS_EDGE_POS: rdata_next = epos_reg;
          `EWR_OFS_REVERSE: rdata_next = {15'h0000, rev_reg};
          `EWR_OFS_SPAN: rdata_next = ref_mode ? {span_start, span_end} : 16'h0000; // RULE6
          default: err_next = 1'b1;
        endcase
      end
    end else if (reg_wr) begin
      unique case (reg_addr)
        `EWR_OFS_WAVE_SET: wtype_next = reg_wdata[7:0];
        `EWR_OFS_EDGE_RDSET: begin
          // one event freezes all three so they describe the same edge
          einfo_next = 16'h0000; // RULE14
          einfo_next[`EWR_BIT_EDGE_POL] = wif.edge_pol0; // RULE2
          einfo_next[`EWR_BIT_MODE_HI:`EWR_BIT_MODE_LO] = wif.edge_mode; // RULE1
          epos_next = {wif.edge_pos0, wif.edge_pos1}; // RULE4 RULE14
          emeas_next = meas_lim; // RULE3 RULE14
          esaved_next = 1'b1;
        end
        `EWR_OFS_REVERSE: begin
          rev_next = reg_wdata[`EWR_BIT_INVERT];
          nv_wr_next = 1'b1; // RULE10
          nv_data_next = {15'h0000, reg_wdata[`EWR_BIT_INVERT]}; // RULE10
        end
        default: err_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 16'h0000;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      wtype_reg <= `EWR_RST_WAVE_TYPE;
      wsaved_reg <= 1'b0;
      esaved_reg <= 1'b0;
      einfo_reg <= 16'h0000;
      epos_reg <= 16'h0000;
      emeas_reg <= 32'sh00000000;
      rev_reg <= `EWR_RST_INVERT;
      nv_wr_reg <= 1'b0;
      nv_data_reg <= 16'h0000;
      snap_reg <= 1'b0;
      mode_prev_reg <= EWR_MODE_EDGE;
    end else begin
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
      wtype_reg <= wtype_next;
      wsaved_reg <= wsaved_next;
      esaved_reg <= esaved_next;
      einfo_reg <= einfo_next;
      epos_reg <= epos_next;
      emeas_reg <= emeas_next;
      rev_reg <= rev_next;
      nv_wr_reg <= nv_wr_next;
      nv_data_reg <= nv_data_next;
      snap_reg <= snap_next;
      mode_prev_reg <= mode_prev_next;
    end
  end

  // ----------------------------------------------------------------------
  // direction status
  // ----------------------------------------------------------------------
  // auto mode follows the workpiece, the fixed modes echo the setting
  always_comb begin
    dir_next = (meas_mode == EWR_MODE_AUTO) ? insert_dir : dir_setting; // RULE9
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dir_reg <= 1'b0;
    end else begin
      dir_reg <= dir_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign reg_rdata = rdata_reg;
  assign reg_ack = ack_reg;
  assign reg_err = err_reg;
  assign dir_status = dir_reg;
  assign measured_value_invert = rev_reg;
  assign nv_wr = nv_wr_reg;
  assign nv_data = nv_data_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_ack_next_cycle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    acc |=> reg_ack ##1 !reg_ack || $past(acc))
    else $error("ack not one cycle after access");

  a_ack_has_cause: assert property (@(posedge sys_clk) disable iff (!rst_b)
    reg_ack |-> $past(acc))
    else $error("ack without access");

  a_meas_in_range: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE3
    (emeas_reg <= `EWR_MEAS_MAX) && (emeas_reg >= `EWR_MEAS_MIN))
    else $error("captured value out of range");

  a_snap_on_read: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE11
    (reg_rd && reg_addr == `EWR_OFS_WAVE_SET) |=> wif.snap_req ##1 !wif.snap_req || $past(reg_rd))
    else $error("waveform read setting did not save a snapshot");

  a_edge_capture: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE14
    (!reg_rd && reg_wr && reg_addr == `EWR_OFS_EDGE_RDSET) |=>
      (einfo_reg[14:13] == $past(wif.edge_mode)) && (epos_reg[15:8] == $past(wif.edge_pos0))
      && (epos_reg[7:0] == $past(wif.edge_pos1)) && esaved_reg)
    else $error("edge capture not coherent");

  a_dir_auto: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE9
    (meas_mode == EWR_MODE_AUTO) |=> (dir_status == $past(insert_dir)))
    else $error("auto mode direction not shown");

  a_span_gated: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE6
    (reg_rd && reg_addr == `EWR_OFS_SPAN && !ref_mode) |=> (reg_rdata == 16'h0000))
    else $error("span points visible outside reference mode");

  a_nv_on_write: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE10
    (!reg_rd && reg_wr && reg_addr == `EWR_OFS_REVERSE) |=>
      nv_wr && (nv_data[0] == $past(reg_wdata[0])) && (measured_value_invert == nv_data[0]))
    else $error("reverse setting not stored");

  a_err_unmapped: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!reg_rd && reg_wr && reg_addr == `EWR_OFS_EDGE_INFO) |=> reg_err && reg_ack)
    else $error("write to read-only register not refused");

  // response shape, mode-dependent outputs and store discipline
  a_err_with_ack: assert property (@(posedge sys_clk) disable iff (!rst_b)
    reg_err |-> reg_ack)
    else $error("refusal without acknowledge");

  a_rdata_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !$past(reg_rd) |-> (reg_rdata == 16'h0000))
    else $error("read data shown without a read");

  a_dir_fixed: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE9
    (meas_mode != EWR_MODE_AUTO) |=> (dir_status == $past(dir_setting)))
    else $error("fixed mode direction not shown");

  a_info_legal: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE1
    (einfo_reg[14:13] != 2'b11) && (einfo_reg[12:0] == 13'h0000))
    else $error("edge info carries an illegal mode or reserved bits");

  a_nv_cause: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE10
    nv_wr |-> $past(reg_wr) && !$past(reg_rd) && ($past(reg_addr) == `EWR_OFS_REVERSE))
    else $error("store pulse without a reverse write");

  a_rev_kept: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE10
    !(reg_wr && !reg_rd && reg_addr == `EWR_OFS_REVERSE) |=> $stable(measured_value_invert))
    else $error("reverse setting changed without a write");

  a_status_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (meas_mode != $past(meas_mode)) && !(reg_wr && !reg_rd && reg_addr == `EWR_OFS_EDGE_RDSET)
      |=> !esaved_reg)
    else $error("mode change left the read status set");

  a_snap_cause: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE11
    wif.snap_req |-> $past(reg_rd) && ($past(reg_addr) == `EWR_OFS_WAVE_SET))
    else $error("snapshot without a waveform setting read");
endmodule : ewr_readout
`default_nettype wire

// ==== testbench/ewr_host.sv ====
// register-port host model for the edge readout block
`include "ewr_map.svh"
`timescale 1ns/1ns
`default_nettype none
module ewr_host #(
  parameter int GAP = 2
) (
  // clock
  input wire logic sys_clk,
  // request
  output logic reg_rd,
  output logic reg_wr,
  output logic [`EWR_ADDR_W-1:0] reg_addr,
  output logic [`EWR_DATA_W-1:0] reg_wdata,
  // answer
  input wire logic [`EWR_DATA_W-1:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic reg_err
);
  // idle port at time zero
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 20'h00000;
    reg_wdata = 16'h0000;
  end

  // one access: request is a one-cycle pulse, the answer has settled one falling edge later
  task automatic access(input logic wr, input logic [19:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic e, output logic ok);
    @(negedge sys_clk);
    reg_rd = !wr;
    reg_wr = wr;
    reg_addr = a;
    // only numeric settings pass here; no character setting is ever written
    reg_wdata = d;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    ok = (reg_ack === 1'b1);
    q = reg_rdata;
    e = reg_err;
    // released lines carry the inverse so a stale value is never mistaken for a hold
    reg_addr = ~a;
    reg_wdata = ~d;
    // spacing between commands, scaled down from the host pause
    repeat (GAP) @(negedge sys_clk);
  endtask : access
endmodule : ewr_host
`default_nettype wire

// ==== testbench/test_edge_waveform_readout_regs.sv ====
// self-checking bench of the edge readout register block
`include "ewr_map.svh"
`timescale 1ns/1ns
`default_nettype none
module test_edge_waveform_readout_regs;
  import ewr_pkg::*;
  localparam logic [7:0] THR = `EWR_EDGE_THRESH;
  localparam int LIMIT = 20000;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_rd, reg_wr, reg_ack, reg_err;
  logic [19:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, nv_data, q, q2;
  logic signed [31:0] meas_value = 32'sd0;
  ewr_mode_t meas_mode = EWR_MODE_EDGE;
  logic insert_dir = 1'b0, dir_setting = 1'b0, ref_mode = 1'b0;
  logic [7:0] span_start = 8'h00, span_end = 8'h00;
  logic samp_valid = 1'b0;
  logic [7:0] samp_idx = 8'h00, samp_level = 8'h00;
  logic dir_status, measured_value_invert, nv_wr;
  logic [7:0] lvl [256];
  logic [7:0] snap [256];
  logic [18:0] ex;
  logic [31:0] mv;
  int fail_count = 0, total_checks = 0, cycles = 0, nv_count = 0, nv0, seed;

  ewr_readout #(.THRESH(THR)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .reg_err(reg_err), .meas_value(meas_value), .meas_mode(meas_mode),
    .insert_dir(insert_dir), .dir_setting(dir_setting), .ref_mode(ref_mode),
    .span_start(span_start), .span_end(span_end), .samp_valid(samp_valid),
    .samp_idx(samp_idx), .samp_level(samp_level), .dir_status(dir_status),
    .measured_value_invert(measured_value_invert), .nv_wr(nv_wr), .nv_data(nv_data));
  ewr_host host (.sys_clk(sys_clk), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err));

  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;

  // store pulses and hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (nv_wr === 1'b1) nv_count++;
    if (cycles == LIMIT) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic acc(input logic wr, input logic [19:0] a, input logic [15:0] d,
                     input logic exp_err, output logic [15:0] r);
    logic e;
    logic ok;
    host.access(wr, a, d, r, e, ok);
    check({ok, e}, {1'b1, exp_err});
  endtask : acc

  // one frame, areas 0..255 in order, top area first
  task automatic send_frame();
    for (int i = 0; i < 256; i++) begin
      @(negedge sys_clk);
      samp_valid = 1'b1;
      samp_idx = i[7:0];
      samp_level = lvl[i];
    end
    @(negedge sys_clk);
    samp_valid = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : send_frame

  // {mode, polarity of edge 0, edge 0, edge 1}; later crossings are ignored
  function automatic logic [18:0] edge_exp();
    logic prev;
    logic [1:0] n;
    logic [18:0] r;
    r = '0;
    n = 2'd0;
    prev = (lvl[0] >= THR);
    for (int i = 1; i < 256; i++) begin
      if ((lvl[i] >= THR) != prev) begin
        if (n == 2'd0) r[16:8] = {!prev, i[7:0]};
        if (n == 2'd1) r[7:0] = i[7:0];
        if (n < 2'd2) n++;
        prev = !prev;
      end
    end
    r[18:17] = n;
    return r;
  endfunction : edge_exp

  function automatic logic [31:0] meas_exp(input logic signed [31:0] v, input logic inv);
    logic signed [31:0] x;
    x = inv ? -v : v;
    if (x > `EWR_MEAS_MAX) x = `EWR_MEAS_MAX;
    if (x < `EWR_MEAS_MIN) x = `EWR_MEAS_MIN;
    return x;
  endfunction : meas_exp

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    seed = $urandom(96677);
    repeat (8) @(negedge sys_clk);
    check({reg_ack, reg_err, dir_status, measured_value_invert, nv_wr, nv_data}, 0);
    rst_b = 1'b1;
    // refused accesses: unmapped, read-only, waveform window
    acc(1'b0, 20'h00000, 16'h0000, 1'b1, q);
    acc(1'b1, `EWR_OFS_EDGE_INFO, 16'h0000, 1'b1, q);
    acc(1'b1, `EWR_OFS_WAVE_DATA, 16'h0000, 1'b1, q);
    // capture runs: corner frames and values first, then random ones
    for (int t = 0; t < 12; t++) begin
      nv0 = nv_count;
      acc(1'b1, `EWR_OFS_REVERSE, {15'h0000, t[0]}, 1'b0, q);
      check({30'(nv_count - nv0), nv_data[0], measured_value_invert}, {30'd1, t[0], t[0]});
      acc(1'b0, `EWR_OFS_REVERSE, 16'h0000, 1'b0, q);
      check(q, {15'h0000, t[0]});
      for (int i = 0; i < 256; i++) begin
        // 0x80 is the lowest light level, 0x7f the highest shade level
        if (t < 3) lvl[i] = ((t == 1 && i >= 10) || (t == 2 && (i < 5 || (i >= 200 && i < 250))))
                            ? 8'h80 : 8'h7f;
        else lvl[i] = 8'($urandom_range(255));
      end
      case (t)
        0: meas_value = 32'sd2000000;
        1: meas_value = -32'sd2000000;
        2: meas_value = 32'sd1999999;
        3: meas_value = -32'sd1999999;
        default: meas_value = $signed($urandom_range(4200000)) - 32'sd2100000;
      endcase
      send_frame();
      ex = edge_exp();
      mv = meas_exp(meas_value, t[0]);
      acc(1'b1, `EWR_OFS_EDGE_RDSET, 16'h0100, 1'b0, q);
      // live inputs move on; the captured set must not follow
      meas_value = ~meas_value;
      acc(1'b0, `EWR_OFS_MEAS_LO, 16'h0000, 1'b0, q);
      acc(1'b0, `EWR_OFS_MEAS_HI, 16'h0000, 1'b0, q2);
      check({q2, q}, mv);
      acc(1'b0, `EWR_OFS_EDGE_INFO, 16'h0000, 1'b0, q);
      check(q & (ex[18:17] == 2'd0 ? 16'h7fff : 16'hffff), {ex[16], ex[18:17], 13'h0000} &
            (ex[18:17] == 2'd0 ? 16'h7fff : 16'hffff));
      acc(1'b0, `EWR_OFS_EDGE_POS, 16'h0000, 1'b0, q);
      if (ex[18:17] == 2'd2) check(q, ex[15:0]);
      if (ex[18:17] == 2'd1) check(q[15:8], ex[15:8]);
      acc(1'b0, `EWR_OFS_EDGE_RDSET, 16'h0000, 1'b0, q);
      check(q[9], 1'b1);
    end
    // direction output per mode; the first change also clears the read status
    for (int m = 2; m >= 0; m--) begin
      meas_mode = ewr_mode_t'(m[1:0]);
      insert_dir = 1'($urandom_range(1));
      dir_setting = !insert_dir;
      repeat (2) @(negedge sys_clk);
      check(dir_status, (m == 2) ? insert_dir : dir_setting);
      acc(1'b0, `EWR_OFS_EDGE_RDSET, 16'h0000, 1'b0, q);
      check(q[9], 1'b0);
    end
    // measurement span only in reference acquisition mode
    span_start = 8'($urandom_range(255));
    span_end = 8'($urandom_range(255));
    acc(1'b0, `EWR_OFS_SPAN, 16'h0000, 1'b0, q);
    check(q, 16'h0000);
    ref_mode = 1'b1;
    acc(1'b0, `EWR_OFS_SPAN, 16'h0000, 1'b0, q);
    check(q, {span_start, span_end});
    // no snapshot since the last mode change: the data window reads as zero
    acc(1'b0, `EWR_OFS_WAVE_DATA, 16'h0000, 1'b0, q);
    check(q, 16'h0000);
    // waveform snapshot survives a newer frame
    for (int i = 0; i < 256; i++) lvl[i] = 8'($urandom_range(255));
    lvl[0] = 8'h00;
    lvl[255] = 8'hff;
    send_frame();
    snap = lvl;
    acc(1'b1, `EWR_OFS_WAVE_SET, 16'h0111, 1'b0, q);
    acc(1'b0, `EWR_OFS_WAVE_SET, 16'h0000, 1'b0, q);
    check(q, 16'h0211);
    for (int i = 0; i < 256; i++) lvl[i] = ~snap[i];
    send_frame();
    for (int k = 0; k < 128; k++) begin
      acc(1'b0, `EWR_OFS_WAVE_DATA + 20'(k), 16'h0000, 1'b0, q);
      check(q, {snap[2 * k], snap[2 * k + 1]});
    end
    tally_and_finish();
  end
endmodule : test_edge_waveform_readout_regs
`default_nettype wire
